/* hw/uotg_status.sv */
// OTG event flags, line status, transfer-status FIFO and frame high over APB
`timescale 1ns/1ps
module uotg_status #(
    parameter int MS_CYCLES = uotg_pkg::MS_CYCLES,
    parameter int DEPTH = uotg_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire uotg_pkg::uotg_pins_type pins,
    input wire logic wake_activity,
    input wire logic xfer_done,
    input wire uotg_pkg::uotg_xfer_type xfer_info,
    input wire logic sof_token,
    input wire logic [10:0] frame_number,
    output logic transaction_complete_flag
);
    localparam int PW = $bits(uotg_pkg::uotg_pins_type);
    localparam int AW = $clog2(DEPTH);

    logic [PW-1:0] s1_q;
    logic [PW-1:0] s2_q;
    logic [PW-1:0] s3_q;
    uotg_pkg::uotg_pins_type sp;
    uotg_pkg::uotg_pins_type pp;
    logic [15:0] tcnt_q;
    logic tick_q;
    logic [15:0] lcnt_q;
    logic stable_q;
    logic [1:0] rec_q;
    logic [1:0] line_now;
    logic line_same;
    logic lst_ev;
    logic [7:0] flags_q;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    uotg_pkg::uotg_xfer_type mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    logic trn_q;
    logic [2:0] frame_number_upper_bits_q;
    logic acc;
    logic wr;
    logic [31:0] rdata_d;
    logic err_d;

    // Two-stage synchroniser per input bit, third stage keeps the old value
    genvar gi;
    generate
        for (gi = 0; gi < PW; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    s1_q[gi] <= uotg_pkg::PINS_RST[gi]; // Idle level, no false edge
                    s2_q[gi] <= uotg_pkg::PINS_RST[gi];
                    s3_q[gi] <= uotg_pkg::PINS_RST[gi];
                end else begin
                    s1_q[gi] <= pins[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                end
            end
        end
    endgenerate

    assign sp = s2_q;
    assign pp = s3_q;

    // Free-running 1 ms timer from the block clock
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tcnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (tcnt_q == 16'(MS_CYCLES - 1)) begin
            tcnt_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            tcnt_q <= tcnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // Line state {SE0, J}; any change restarts the stability count
    assign line_now = {sp.se0, sp.j_state_indication};
    assign line_same = (line_now == {pp.se0, pp.j_state_indication});
    assign lst_ev = line_same && !stable_q && (lcnt_q == 16'(MS_CYCLES - 1))
                    && (line_now != rec_q);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lcnt_q <= 16'h0000;
            stable_q <= 1'b0;
            rec_q <= 2'h0;
        end else if (!line_same) begin
            lcnt_q <= 16'h0000;
            stable_q <= 1'b0;
        end else if (lcnt_q != 16'(MS_CYCLES - 1)) begin
            lcnt_q <= lcnt_q + 16'h0001;
        end else if (!stable_q) begin
            stable_q <= 1'b1;
            rec_q <= line_now;
        end
    end

    // Hardware set terms for each event bit
    always_comb begin
        set_v = 8'h00;
        set_v[uotg_pkg::B_ID] = sp.id ^ pp.id;
        set_v[uotg_pkg::B_TMR] = tick_q;
        set_v[uotg_pkg::B_LST] = lst_ev;
        set_v[uotg_pkg::B_ACT] = wake_activity;
        set_v[uotg_pkg::B_SVD] = sp.sess_end & ~pp.sess_end;
        set_v[uotg_pkg::B_SEND] = sp.sess_end ^ pp.sess_end;
        set_v[uotg_pkg::B_VBUS] = sp.a_vbus_valid ^ pp.a_vbus_valid;
    end

    // APB access completes on the second access cycle
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign clr_v = (wr && paddr == uotg_pkg::OFS_EVENT) ? pwdata[7:0] : 8'h00;

    // Write-one-to-clear; a set in the same cycle wins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= uotg_pkg::EVENT_RST;
        end else begin
            flags_q <= ((flags_q & ~clr_v) | set_v) & uotg_pkg::EVENT_MASK;
        end
    end

    // Report FIFO; a full FIFO drops the new report rather than overwrite
    assign push = xfer_done && (cnt_q != (AW + 1)'(DEPTH));
    assign pop = wr && (paddr == uotg_pkg::OFS_USBEV) && pwdata[uotg_pkg::B_TRN]
                 && (cnt_q != '0);

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wp_q] <= xfer_info;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Completion flag follows FIFO occupancy, so a push beats a pop
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            trn_q <= 1'b0;
        end else begin
            trn_q <= push || (cnt_q > (AW + 1)'(1)) || (cnt_q != '0 && !pop);
        end
    end

    // Upper frame bits reload on each start-of-frame token
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            frame_number_upper_bits_q <= uotg_pkg::FRAME_NUMBER_UPPER_BITS_RST;
        end else if (sof_token) begin
            frame_number_upper_bits_q <= frame_number[10:8];
        end
    end

    // Read mux; high bits are constant zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        unique case (paddr)
            uotg_pkg::OFS_EVENT: rdata_d[7:0] = flags_q;
            uotg_pkg::OFS_STATUS: begin
                rdata_d[uotg_pkg::B_ID] = sp.id;
                rdata_d[uotg_pkg::B_LST] = stable_q;
                rdata_d[uotg_pkg::B_SVD] = sp.sess_valid;
                rdata_d[uotg_pkg::B_SEND] = sp.sess_end;
                rdata_d[uotg_pkg::B_VBUS] = sp.a_vbus_valid;
            end
            uotg_pkg::OFS_XFER: begin
                if (trn_q) begin
                    rdata_d[7:4] = mem_q[rp_q].last_endpoint_number;
                    rdata_d[3] = mem_q[rp_q].dir_tx;
                    rdata_d[2] = mem_q[rp_q].pingpong_bank_indicator;
                end
            end
            uotg_pkg::OFS_FRAME_NUMBER_UPPER_BITS: rdata_d[2:0] = frame_number_upper_bits_q;
            uotg_pkg::OFS_USBEV: rdata_d[uotg_pkg::B_TRN] = trn_q;
            default: err_d = 1'b1;
        endcase
    end

    // One wait state keeps the read path off the mux timing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ? rdata_d : 32'h0000_0000;
            pslverr <= psel && penable && !pready && err_d;
        end
    end

    // Registered copy of the completion flag for the interrupt logic
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            transaction_complete_flag <= 1'b0;
        end else begin
            transaction_complete_flag <= trn_q;
        end
    end

    a_timer_sets: assert property (@(posedge mclk) disable iff (!nrst)
        tick_q |=> flags_q[uotg_pkg::B_TMR]) else $error("timer tick lost");

    a_w1c_clears: assert property (@(posedge mclk) disable iff (!nrst)
        (clr_v[uotg_pkg::B_ACT] && !wake_activity) |=> !flags_q[uotg_pkg::B_ACT])
        else $error("write one did not clear");

    a_set_wins: assert property (@(posedge mclk) disable iff (!nrst)
        (clr_v[uotg_pkg::B_ACT] && wake_activity) |=> flags_q[uotg_pkg::B_ACT])
        else $error("set lost to clear");

    a_id_change: assert property (@(posedge mclk) disable iff (!nrst)
        ($changed(s2_q[5])) |=> flags_q[uotg_pkg::B_ID])
        else $error("id change not flagged");

    a_high_zero: assert property (@(posedge mclk) disable iff (!nrst)
        pready |-> prdata[31:8] == 24'h000000) else $error("high bits not zero");

    a_fifo_pop: assert property (@(posedge mclk) disable iff (!nrst)
        (pop && !push) |=> cnt_q == $past(cnt_q) - 1'b1) else $error("pop missed");

    a_trn_occupancy: assert property (@(posedge mclk) disable iff (!nrst)
        trn_q == (cnt_q != '0))
        else $error("flag off occupancy");

    a_frame_number_upper_bits_load: assert property (@(posedge mclk) disable iff (!nrst)
        sof_token |=> frame_number_upper_bits_q == $past(frame_number[10:8])) else $error("frame high stale");

    a_stable_hold: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(stable_q) |-> $past(line_same, 1) && lcnt_q == 16'(MS_CYCLES - 1))
        else $error("stable too early");

    a_ready_pulse: assert property (@(posedge mclk) disable iff (!nrst)
        pready |=> !pready) else $error("pready held");

    // Timer enable pulse shape
    a_tick_single: assert property (@(posedge mclk) disable iff (!nrst)
        tick_q |=> !tick_q)
        else $error("timer tick longer than one cycle");

    a_tick_wrap: assert property (@(posedge mclk) disable iff (!nrst)
        tick_q |-> tcnt_q == 16'h0000)
        else $error("timer tick off the wrap");

    a_tcnt_range: assert property (@(posedge mclk) disable iff (!nrst)
        tcnt_q <= 16'(MS_CYCLES - 1))
        else $error("timer count out of range");

    // Event flags: every clear without a same-cycle set lands, every set lands, nothing else sets
    a_w1c_all: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 (flags_q & $past(clr_v) & ~$past(set_v)) == 8'h00)
        else $error("flag survived its clear");

    a_set_all: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 ($past(set_v) & uotg_pkg::EVENT_MASK & ~flags_q) == 8'h00)
        else $error("hardware set lost");

    a_hw_only_sets: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 (flags_q & ~$past(flags_q) & ~$past(set_v)) == 8'h00)
        else $error("flag set without an event");

    a_bit1_zero: assert property (@(posedge mclk) disable iff (!nrst)
        flags_q[1] == 1'b0)
        else $error("unused event bit set");

    a_sess_fall: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(sp.sess_end) |=> flags_q[uotg_pkg::B_SVD])
        else $error("session end entry not flagged");

    a_send_change: assert property (@(posedge mclk) disable iff (!nrst)
        $changed(sp.sess_end) |=> flags_q[uotg_pkg::B_SEND])
        else $error("session end change not flagged");

    a_vbus_change: assert property (@(posedge mclk) disable iff (!nrst)
        $changed(sp.a_vbus_valid) |=> flags_q[uotg_pkg::B_VBUS])
        else $error("vbus valid change not flagged");

    a_wake_sets: assert property (@(posedge mclk) disable iff (!nrst)
        wake_activity |=> flags_q[uotg_pkg::B_ACT])
        else $error("wake activity not flagged");

    // Line state stability and its recorded value
    a_line_event: assert property (@(posedge mclk) disable iff (!nrst)
        ($rose(stable_q) && $changed(rec_q)) |-> flags_q[uotg_pkg::B_LST])
        else $error("new stable line state not flagged");

    a_stable_drop: assert property (@(posedge mclk) disable iff (!nrst)
        !line_same |=> !stable_q)
        else $error("stable kept over a line change");

    a_stable_rec: assert property (@(posedge mclk) disable iff (!nrst)
        (stable_q && line_same) |-> rec_q == line_now)
        else $error("recorded line state stale");

    // Report queue occupancy
    a_fifo_full: assert property (@(posedge mclk) disable iff (!nrst)
        (xfer_done && cnt_q == (AW + 1)'(DEPTH)) |=> $stable(wp_q))
        else $error("full queue overwritten");

    a_cnt_max: assert property (@(posedge mclk) disable iff (!nrst)
        cnt_q <= (AW + 1)'(DEPTH))
        else $error("queue count above depth");

    a_push_count: assert property (@(posedge mclk) disable iff (!nrst)
        (push && !pop) |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("push missed");

    a_head_empty: assert property (@(posedge mclk) disable iff (!nrst)
        (pready && $past(paddr) == uotg_pkg::OFS_XFER && !$past(trn_q))
        |-> prdata == 32'h0000_0000) else $error("empty head not zero");

    a_tcf_follows: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 transaction_complete_flag == $past(trn_q))
        else $error("completion output lags wrongly");

    // Frame high field holds between tokens
    a_frame_number_upper_bits_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !sof_token |=> $stable(frame_number_upper_bits_q))
        else $error("frame high moved without token");

    // Register bus response shape
    a_ready_access: assert property (@(posedge mclk) disable iff (!nrst)
        pready |-> $past(psel) && $past(penable))
        else $error("pready without access");

    a_err_ready: assert property (@(posedge mclk) disable iff (!nrst)
        pslverr |-> pready)
        else $error("pslverr without pready");

    a_rdata_idle: assert property (@(posedge mclk) disable iff (!nrst)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside response");

    a_write_rdata: assert property (@(posedge mclk) disable iff (!nrst)
        (pready && $past(pwrite)) |-> prdata == 32'h0000_0000)
        else $error("read data on a write");

    a_status_id: assert property (@(posedge mclk) disable iff (!nrst)
        (pready && $past(paddr) == uotg_pkg::OFS_STATUS && !$past(pwrite))
        |-> prdata[uotg_pkg::B_ID] == $past(sp.id)) else $error("id status wrong");
endmodule

/* hw/uotg_pkg.sv */
// Package of constants and types for the OTG status and transfer report block
// Summary of operation
// - Cable ID pin change sets event bit 7
// - Each 1 ms timer expiry sets bit 6
// - New stable line state after 1 ms sets bit 5
// - Wake-up bus activity sets bit 4
// - VBUS dropping below session end sets bit 3
// - Session end comparator change sets bit 2
// - A VBUS valid comparator change sets bit 0
// - Writing one clears flag; hardware alone sets
// - Status bit 7 mirrors ID pin level
// - Status bit 5 shows line stable 1 ms
// - Status bit 3 shows VBUS above session valid
// - Status bit 2 shows B session end
// - Status bit 0 shows A VBUS valid
// - Head bits 7-4 give endpoint number
// - Head bit 3 gives transmit direction
// - Head bit 2 gives odd bank
// - Four-entry FIFO, oldest entry shown
// - Head valid only while completion flag set
// - Clearing completion flag pops the FIFO
// - Bits 31-8 of reports read zero
// - Frame high bits reload on SOF token
package uotg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_EVENT = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_XFER = 8'h08;
    localparam logic [7:0] OFS_FRAME_NUMBER_UPPER_BITS = 8'h0C;
    localparam logic [7:0] OFS_USBEV = 8'h10;
    // Event and status bit positions
    localparam int B_ID = 7;
    localparam int B_TMR = 6;
    localparam int B_LST = 5;
    localparam int B_ACT = 4;
    localparam int B_SVD = 3;
    localparam int B_SEND = 2;
    localparam int B_VBUS = 0;
    localparam int B_TRN = 3;
    // Implemented event bits, bit 1 and bits 31-8 read zero
    localparam logic [7:0] EVENT_MASK = 8'hFD;
    localparam logic [7:0] EVENT_RST = 8'h00;
    localparam logic [2:0] FRAME_NUMBER_UPPER_BITS_RST = 3'h0;
    localparam logic [5:0] PINS_RST = 6'h20; // Idle pins: no cable, ID high
    // Timing: 1 ms at a 100 ns clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_TIME_NS = 1000000;
    localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 4;
    // Pin and comparator inputs, synchronised as one vector
    typedef struct packed {
        logic id;
        logic se0;
        logic j_state_indication;
        logic sess_end;
        logic sess_valid;
        logic a_vbus_valid;
    } uotg_pins_type;
    // One completed-transaction report
    typedef struct packed {
        logic [3:0] last_endpoint_number;
        logic dir_tx;
        logic pingpong_bank_indicator;
    } uotg_xfer_type;
endpackage

/* verification/uotg_peer.sv */
// Behavioural USB peer driving the pin, transfer and frame inputs
`timescale 1ns/1ps
module uotg_peer (
    input wire logic mclk,
    output uotg_pkg::uotg_pins_type pins,
    output logic wake_activity,
    output logic xfer_done,
    output uotg_pkg::uotg_xfer_type xfer_info,
    output logic sof_token,
    output logic [10:0] frame_number
);
    // No cable, idle line, no strobes at start
    initial begin
        pins = 6'h20;
        wake_activity = 1'b0;
        xfer_done = 1'b0;
        xfer_info = 6'h3F;
        sof_token = 1'b0;
        frame_number = 11'h7FF;
    end
    // Cable and comparator levels change right after an edge
    task automatic set_pins(input logic [5:0] v);
        @(posedge mclk);
        pins <= v;
    endtask
    task automatic wake();
        @(posedge mclk);
        wake_activity <= 1'b1;
        @(posedge mclk);
        wake_activity <= 1'b0;
    endtask
    // Report data is garbage outside its strobe, so the block cannot lean on it
    task automatic xfer(input logic [5:0] v);
        @(posedge mclk);
        xfer_done <= 1'b1;
        xfer_info <= v;
        @(posedge mclk);
        xfer_done <= 1'b0;
        xfer_info <= ~v;
    endtask
    task automatic sof(input logic [10:0] f);
        @(posedge mclk);
        sof_token <= 1'b1;
        frame_number <= f;
        @(posedge mclk);
        sof_token <= 1'b0;
        frame_number <= ~f;
    endtask
endmodule

/* verification/uotg_status_tb_top.sv */
// Self-checking bench for the OTG status and transfer report block
`timescale 1ns/1ps
module uotg_status_tb_top;
    localparam int MS = 20;
    localparam logic [5:0] PV [7] = '{6'h00, 6'h04, 6'h00, 6'h03, 6'h0B, 6'h2B, 6'h2B};
    localparam logic [7:0] EV [7] = '{8'h80, 8'h0C, 8'h04, 8'h01, 8'h20, 8'h80, 8'h10};
    localparam logic [7:0] ST [7] = '{8'h20, 8'h24, 8'h20, 8'h29, 8'h29, 8'hA9, 8'hA9};
    localparam logic [5:0] XI [5] = '{6'h3E, 6'h01, 6'h27, 6'h18, 6'h0F};
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, tcf, err, wake, xdone, sof;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] fnum;
    uotg_pkg::uotg_pins_type pins;
    uotg_pkg::uotg_xfer_type xinfo;
    int n_fail = 0;
    int comparisons = 0;

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    uotg_status #(.MS_CYCLES(MS), .DEPTH(4)) dut (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .wake_activity(wake),
        .xfer_done(xdone), .xfer_info(xinfo), .sof_token(sof), .frame_number(fnum),
        .transaction_complete_flag(tcf));
    uotg_peer peer (.mclk(mclk), .pins(pins), .wake_activity(wake), .xfer_done(xdone),
        .xfer_info(xinfo), .sof_token(sof), .frame_number(fnum));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready under a bound, takes data at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        chk({31'h0, tcf}, 32'h0);
        rchk(uotg_pkg::OFS_XFER, 32'h0);
        rchk(uotg_pkg::OFS_FRAME_NUMBER_UPPER_BITS, 32'h0);
        rchk(8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        // No event may be latched out of reset; the first tick is still ahead
        apb(1'b0, uotg_pkg::OFS_EVENT, 32'h0);
        chk(rd & 32'hFFFFFFBF, 32'h0);
        repeat (10) @(posedge mclk);
        // Each step clears flags, makes one cable change (a wake pulse in the last step), then reads flags and levels
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, uotg_pkg::OFS_EVENT, 32'hFF);
            if (i == 6) peer.wake();
            else peer.set_pins(PV[i]);
            if (i == 4) begin
                repeat (3) @(posedge mclk);
                rchk(uotg_pkg::OFS_STATUS, 32'h09);
            end
            repeat (MS + 10) @(posedge mclk);
            apb(1'b0, uotg_pkg::OFS_EVENT, 32'h0);
            chk(rd & 32'hFFFFFFBF, {24'h0, EV[i]});
            chk(rd & 32'h40, 32'h40);
            rchk(uotg_pkg::OFS_STATUS, {24'h0, ST[i]});
            if (i == 1) begin
                apb(1'b1, uotg_pkg::OFS_EVENT, 32'h04);
                apb(1'b0, uotg_pkg::OFS_EVENT, 32'h0);
                chk(rd & 32'hBF, 32'h08);
            end
        end
        // Wake pulse lands on the very edge that takes the clear; the set must win
        fork
            apb(1'b1, uotg_pkg::OFS_EVENT, 32'hFF);
            begin
                repeat (2) @(posedge mclk);
                peer.wake();
            end
        join
        apb(1'b0, uotg_pkg::OFS_EVENT, 32'h0);
        chk(rd & 32'h10, 32'h10);
        // Five reports into a four-deep queue; the last one is dropped
        for (int i = 0; i < 5; i++) peer.xfer(XI[i]);
        repeat (3) @(posedge mclk);
        chk({31'h0, tcf}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            rchk(uotg_pkg::OFS_XFER, {24'h0, XI[i], 2'b00});
            rchk(uotg_pkg::OFS_USBEV, 32'h08);
            apb(1'b1, uotg_pkg::OFS_USBEV, 32'h08);
        end
        rchk(uotg_pkg::OFS_XFER, 32'h0);
        rchk(uotg_pkg::OFS_USBEV, 32'h0);
        peer.sof(11'h5A3);
        rchk(uotg_pkg::OFS_FRAME_NUMBER_UPPER_BITS, 32'h5);
        peer.sof(11'h2FF);
        rchk(uotg_pkg::OFS_FRAME_NUMBER_UPPER_BITS, 32'h2);
        tally_and_finish();
    end
endmodule
